// [hdl/anc_core.sv]
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module anc_core
    import anc_pkg::*;
#(
    parameter int MEM_AW = 16,
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [MEM_AW-1:0] mem_addr_o,
    output logic [15:0] mem_wdata_o,
    input wire logic [15:0] mem_rdata_i,
    output logic irq_o
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        anc_state_t st;
        logic [31:0] acc, stk, opnd;
        logic [3:0] op;
        logic zero, neg, bad_dec, range;
        logic [ANC_EV_W-1:0] stat, mask;
        logic irq;
        logic [MEM_AW-1:0] src, dst;
        logic [31:0] cnt;
        logic half;
        logic [7:0] hold_b;
        logic [15:0] hold_w;
        logic mreq, mwe;
        logic [MEM_AW-1:0] maddr;
        logic [15:0] mwdata;
        logic aw_have, w_have;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready, wready, bvalid;
        logic [1:0] bresp;
        logic arready, rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } anc_reg_t;
    localparam anc_reg_t ANC_RST = '{
        st: ANC_ST_IDLE, acc: ANC_RST_WORD, stk: ANC_RST_WORD, opnd: ANC_RST_WORD,
        op: 4'h0, mask: ANC_RST_MASK, cnt: ANC_RST_WORD, rdata: ANC_RST_WORD,
        wdata: ANC_RST_WORD, default: '0
    };

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] anc_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] s);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : anc_strb
    // Character code to digit; anything else maps to zero
    function automatic logic [3:0] anc_chr2hex(input logic [7:0] c);
        logic [7:0] t;
        t = 8'h00;
        if (c >= ANC_CHR_DIGIT0 && c <= ANC_CHR_DIGIT9) begin
            t = c - ANC_CHR_DIGIT0;
        end else if (c >= ANC_CHR_LETTER_A && c <= ANC_CHR_LETTER_F) begin
            t = c - ANC_CHR_LETTER_A + 8'h0a;
        end
        return t[3:0];
    endfunction : anc_chr2hex
    function automatic logic [7:0] anc_hex2chr(input logic [3:0] h);
        return (h <= 4'h9) ? ANC_CHR_DIGIT0 + {4'h0, h} : ANC_CHR_LETTER_A + {4'h0, h} - 8'h0a;
    endfunction : anc_hex2chr
    // Table must fit in data memory
    function automatic logic anc_range_bad(input logic [31:0] cnt, input logic [31:0] src,
                                           input logic [31:0] dst, input logic text_to_hex);
        logic [33:0] lim;
        logic [33:0] out_words;
        lim = 34'd1 << MEM_AW;
        out_words = text_to_hex ? 34'({1'b0, cnt} + 33'd1) >> 1 : {1'b0, cnt, 1'b0};
        return (cnt == 32'h0000_0000) || (34'(src) + 34'(cnt) > lim)
            || (34'(dst) + out_words > lim);
    endfunction : anc_range_bad
    anc_reg_t r_ff;
    anc_reg_t nxt_r;
    logic [31:0] dec_to_bin;
    logic [31:0] bin_to_dec;
    logic [31:0] gray_dec;
    logic bad_digit;

    anc_conv u_conv (
        .acc_i(r_ff.acc),
        .dec_to_bin_o(dec_to_bin),
        .bin_to_dec_o(bin_to_dec),
        .gray_dec_o(gray_dec),
        .bad_digit_o(bad_digit)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic busy;
    logic wr_fire;
    logic go;
    logic [ANC_EV_W-1:0] ev;
    logic [ANC_EV_W-1:0] clr;
    logic [7:0] pair_b;
    logic [3:0] pstrb;

    always_comb begin
        nxt_r = r_ff;
        ev = '0;
        clr = '0;
        go = 1'b0;
        busy = (r_ff.st != ANC_ST_IDLE);
        wr_fire = r_ff.aw_have && r_ff.w_have && !r_ff.bvalid;
        pstrb = busy ? 4'h0 : r_ff.wstrb;
        pair_b = {anc_chr2hex(mem_rdata_i[15:8]), anc_chr2hex(mem_rdata_i[7:0])};
        nxt_r.mreq = 1'b0;
        nxt_r.mwe = 1'b0;
        // Bus slave: address and data are taken in either order
        if (s_axi_awvalid_i && r_ff.awready) begin
            nxt_r.aw_have = 1'b1;
            nxt_r.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && r_ff.wready) begin
            nxt_r.w_have = 1'b1;
            nxt_r.wdata = s_axi_wdata_i;
            nxt_r.wstrb = s_axi_wstrb_i;
        end
        nxt_r.bvalid = r_ff.bvalid && !s_axi_bready_i;
        if (wr_fire) begin
            nxt_r.aw_have = 1'b0;
            nxt_r.w_have = 1'b0;
            nxt_r.bvalid = 1'b1;
            nxt_r.bresp = ANC_RESP_OKAY;
            // Parameter writes while a table walk runs are dropped
            unique case ({r_ff.awaddr[ADDR_W-1:2], 2'b00})
                ANC_OFS_CTRL: begin
                    if (r_ff.wstrb[0] && !busy) begin
                        nxt_r.op = r_ff.wdata[3:0];
                    end
                    go = r_ff.wstrb[1] && r_ff.wdata[ANC_CTRL_GO_BIT] && !busy;
                end
                ANC_OFS_ACC: nxt_r.acc = anc_strb(r_ff.acc, r_ff.wdata, pstrb);
                ANC_OFS_STACK1: nxt_r.stk = anc_strb(r_ff.stk, r_ff.wdata, pstrb);
                ANC_OFS_OPERAND: nxt_r.opnd = anc_strb(r_ff.opnd, r_ff.wdata, pstrb);
                ANC_OFS_INT_STAT: clr = r_ff.wstrb[0] ? r_ff.wdata[ANC_EV_W-1:0] : '0;
                ANC_OFS_INT_MASK: nxt_r.mask = r_ff.wstrb[0] ? r_ff.wdata[ANC_EV_W-1:0] : r_ff.mask;
                ANC_OFS_FLAGS: ;
                default: nxt_r.bresp = ANC_RESP_SLVERR;
            endcase
        end
        nxt_r.rvalid = r_ff.rvalid && !s_axi_rready_i;
        if (s_axi_arvalid_i && r_ff.arready) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp = ANC_RESP_OKAY;
            nxt_r.rdata = 32'h0000_0000;
            unique case ({s_axi_araddr_i[ADDR_W-1:2], 2'b00})
                ANC_OFS_CTRL: nxt_r.rdata[3:0] = r_ff.op;
                ANC_OFS_FLAGS: begin
                    nxt_r.rdata[ANC_FLAG_ZERO_BIT] = r_ff.zero;
                    nxt_r.rdata[ANC_FLAG_NEG_BIT] = r_ff.neg;
                    nxt_r.rdata[ANC_FLAG_BADDEC_BIT] = r_ff.bad_dec;
                    nxt_r.rdata[ANC_FLAG_RANGE_BIT] = r_ff.range;
                    nxt_r.rdata[ANC_FLAG_BUSY_BIT] = busy;
                end
                ANC_OFS_ACC: nxt_r.rdata = r_ff.acc;
                ANC_OFS_STACK1: nxt_r.rdata = r_ff.stk;
                ANC_OFS_OPERAND: nxt_r.rdata = r_ff.opnd;
                ANC_OFS_INT_STAT: nxt_r.rdata[ANC_EV_W-1:0] = r_ff.stat;
                ANC_OFS_INT_MASK: nxt_r.rdata[ANC_EV_W-1:0] = r_ff.mask;
                default: nxt_r.rresp = ANC_RESP_SLVERR;
            endcase
        end
        // Operation sequencer
        unique case (r_ff.st)
            ANC_ST_IDLE: begin
                if (go) begin
                    unique case (nxt_r.op)
                        ANC_OP_DEC_TO_RADIX2: begin
                            nxt_r.acc = dec_to_bin;
                            nxt_r.bad_dec = bad_digit;
                            ev[ANC_EV_BADDEC_BIT] = bad_digit;
                            nxt_r.zero = (dec_to_bin == 32'h0000_0000);
                            ev[ANC_EV_DONE_BIT] = 1'b1;
                        end
                        ANC_OP_RADIX2_TO_DEC: begin
                            nxt_r.acc = bin_to_dec;
                            nxt_r.zero = (bin_to_dec == 32'h0000_0000);
                            ev[ANC_EV_DONE_BIT] = 1'b1;
                        end
                        ANC_OP_ONES_COMPLEMENT: begin
                            nxt_r.acc = ~r_ff.acc;
                            ev[ANC_EV_DONE_BIT] = 1'b1;
                        end
                        ANC_OP_GRAY_TO_DEC: begin
                            nxt_r.acc = gray_dec;
                            nxt_r.zero = (gray_dec == 32'h0000_0000);
                            ev[ANC_EV_DONE_BIT] = 1'b1;
                        end
                        ANC_OP_TEXT_TO_HEXDIGIT, ANC_OP_HEXDIGIT_TO_TEXT: begin
                            // Count from stack, start from accumulator
                            nxt_r.range = anc_range_bad(r_ff.stk, r_ff.acc, r_ff.opnd,
                                                        nxt_r.op == ANC_OP_TEXT_TO_HEXDIGIT);
                            ev[ANC_EV_RANGE_BIT] = nxt_r.range;
                            if (nxt_r.range) begin
                                ev[ANC_EV_DONE_BIT] = 1'b1;
                            end else begin
                                nxt_r.src = r_ff.acc[MEM_AW-1:0];
                                nxt_r.dst = r_ff.opnd[MEM_AW-1:0];
                                nxt_r.cnt = r_ff.stk;
                                nxt_r.half = 1'b0;
                                nxt_r.mreq = 1'b1;
                                nxt_r.maddr = r_ff.acc[MEM_AW-1:0];
                                nxt_r.st = ANC_ST_RD;
                            end
                        end
                        default: ev[ANC_EV_DONE_BIT] = 1'b1;
                    endcase
                end
            end
            ANC_ST_RD: nxt_r.st = ANC_ST_WAIT;
            ANC_ST_WAIT: begin
                nxt_r.cnt = r_ff.cnt - 32'd1;
                nxt_r.src = r_ff.src + 1'b1;
                if (r_ff.op == ANC_OP_TEXT_TO_HEXDIGIT) begin
                    // Two words of text per word of digits
                    if (r_ff.half) begin
                        nxt_r.half = 1'b0;
                        nxt_r.mwdata = {r_ff.hold_b, pair_b};
                        nxt_r.st = ANC_ST_WR;
                    end else if (r_ff.cnt == 32'd1) begin
                        nxt_r.mwdata = {pair_b, 8'h00};
                        nxt_r.st = ANC_ST_WR;
                    end else begin
                        nxt_r.half = 1'b1;
                        nxt_r.hold_b = pair_b;
                        nxt_r.maddr = nxt_r.src;
                        nxt_r.st = ANC_ST_RD;
                    end
                end else begin
                    // Upper two digits go out first
                    nxt_r.hold_w = mem_rdata_i;
                    nxt_r.mwdata = {anc_hex2chr(mem_rdata_i[15:12]),
                                    anc_hex2chr(mem_rdata_i[11:8])};
                    nxt_r.st = ANC_ST_WR;
                end
                nxt_r.mreq = 1'b1;
                if (nxt_r.st == ANC_ST_WR) begin
                    nxt_r.mwe = 1'b1;
                    nxt_r.maddr = r_ff.dst;
                    nxt_r.dst = r_ff.dst + 1'b1;
                end
            end
            ANC_ST_WR: begin
                if (r_ff.op == ANC_OP_HEXDIGIT_TO_TEXT && !r_ff.half) begin
                    nxt_r.half = 1'b1;
                    nxt_r.mreq = 1'b1;
                    nxt_r.mwe = 1'b1;
                    nxt_r.maddr = r_ff.dst;
                    nxt_r.dst = r_ff.dst + 1'b1;
                    nxt_r.mwdata = {anc_hex2chr(r_ff.hold_w[7:4]), anc_hex2chr(r_ff.hold_w[3:0])};
                end else if (r_ff.cnt != 32'h0000_0000) begin
                    nxt_r.half = 1'b0;
                    nxt_r.mreq = 1'b1;
                    nxt_r.maddr = r_ff.src;
                    nxt_r.st = ANC_ST_RD;
                end else begin
                    ev[ANC_EV_DONE_BIT] = 1'b1;
                    nxt_r.st = ANC_ST_IDLE;
                end
            end
            default: nxt_r.st = ANC_ST_IDLE;
        endcase

        nxt_r.neg = nxt_r.acc[31];
        // Set wins over a same-cycle clear
        nxt_r.stat = (r_ff.stat & ~clr) | ev;
        nxt_r.irq = |(nxt_r.stat & nxt_r.mask);
        nxt_r.awready = !nxt_r.aw_have && !nxt_r.bvalid;
        nxt_r.wready = !nxt_r.w_have && !nxt_r.bvalid;
        nxt_r.arready = !nxt_r.rvalid;
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            r_ff <= ANC_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign s_axi_awready_o = r_ff.awready;
    assign s_axi_wready_o = r_ff.wready;
    assign s_axi_bresp_o = r_ff.bresp;
    assign s_axi_bvalid_o = r_ff.bvalid;
    assign s_axi_arready_o = r_ff.arready;
    assign s_axi_rdata_o = r_ff.rdata;
    assign s_axi_rresp_o = r_ff.rresp;
    assign s_axi_rvalid_o = r_ff.rvalid;
    assign mem_req_o = r_ff.mreq;
    assign mem_we_o = r_ff.mwe;
    assign mem_addr_o = r_ff.maddr;
    assign mem_wdata_o = r_ff.mwdata;
    assign irq_o = r_ff.irq;
endmodule : anc_core

// [hdl/anc_pkg.sv]
package anc_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ANC_OFS_CTRL = 8'h00;
    localparam logic [7:0] ANC_OFS_FLAGS = 8'h04;
    localparam logic [7:0] ANC_OFS_ACC = 8'h08;
    localparam logic [7:0] ANC_OFS_STACK1 = 8'h0c;
    localparam logic [7:0] ANC_OFS_OPERAND = 8'h10;
    localparam logic [7:0] ANC_OFS_INT_STAT = 8'h14;
    localparam logic [7:0] ANC_OFS_INT_MASK = 8'h18;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ANC_CTRL_GO_BIT = 8;
    localparam int ANC_FLAG_ZERO_BIT = 0;
    localparam int ANC_FLAG_NEG_BIT = 1;
    localparam int ANC_FLAG_BADDEC_BIT = 2;
    localparam int ANC_FLAG_RANGE_BIT = 3;
    localparam int ANC_FLAG_BUSY_BIT = 4;
    localparam int ANC_EV_DONE_BIT = 0;
    localparam int ANC_EV_BADDEC_BIT = 1;
    localparam int ANC_EV_RANGE_BIT = 2;
    localparam int ANC_EV_W = 3;
    localparam int ANC_GRAY_IN_W = 16;
    localparam int ANC_GRAY_OUT_W = 10;

    // ----------------------------------------------------------------
    // Operation codes and constants
    // ----------------------------------------------------------------
    localparam logic [3:0] ANC_OP_DEC_TO_RADIX2 = 4'h0;
    localparam logic [3:0] ANC_OP_RADIX2_TO_DEC = 4'h1;
    localparam logic [3:0] ANC_OP_ONES_COMPLEMENT = 4'h2;
    localparam logic [3:0] ANC_OP_GRAY_TO_DEC = 4'h3;
    localparam logic [3:0] ANC_OP_TEXT_TO_HEXDIGIT = 4'h4;
    localparam logic [3:0] ANC_OP_HEXDIGIT_TO_TEXT = 4'h5;
    localparam logic [7:0] ANC_CHR_DIGIT0 = 8'h30;
    localparam logic [7:0] ANC_CHR_DIGIT9 = 8'h39;
    localparam logic [7:0] ANC_CHR_LETTER_A = 8'h41;
    localparam logic [7:0] ANC_CHR_LETTER_F = 8'h46;
    localparam logic [1:0] ANC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ANC_RESP_SLVERR = 2'h2;
    localparam logic [31:0] ANC_RST_WORD = 32'h0000_0000;
    localparam logic [ANC_EV_W-1:0] ANC_RST_MASK = 3'h0;

    typedef enum logic [3:0] {
        ANC_ST_IDLE = 4'b0001,
        ANC_ST_RD = 4'b0010,
        ANC_ST_WAIT = 4'b0100,
        ANC_ST_WR = 4'b1000
    } anc_state_t;
endpackage : anc_pkg

// [hdl/anc_conv.sv]
`timescale 1ns/1ps
module anc_conv
    import anc_pkg::*;
(
    input wire logic [31:0] acc_i,
    output logic [31:0] dec_to_bin_o,
    output logic [31:0] bin_to_dec_o,
    output logic [31:0] gray_dec_o,
    output logic bad_digit_o
);
    // Double dabble; values above 99999999 lose their top digits
    function automatic logic [31:0] anc_bin2bcd(input logic [31:0] v);
        logic [63:0] sh;
        sh = {32'h0000_0000, v};
        for (int i = 0; i < 32; i++) begin
            for (int d = 0; d < 8; d++) begin
                if (sh[32+4*d +: 4] > 4'h4) begin
                    sh[32+4*d +: 4] = sh[32+4*d +: 4] + 4'h3;
                end
            end
            sh = {sh[62:0], 1'b0};
        end
        return sh[63:32];
    endfunction : anc_bin2bcd

    logic [31:0] bin_acc;
    logic bad;
    logic [ANC_GRAY_IN_W-1:0] gray_bin;
    logic [31:0] gray_bcd;

    always_comb begin
        bin_acc = 32'h0000_0000;
        bad = 1'b0;
        for (int d = 7; d >= 0; d--) begin
            bin_acc = 32'(bin_acc * 32'd10) + {28'h000_0000, acc_i[4*d +: 4]};
            if (acc_i[4*d +: 4] > 4'h9) begin
                bad = 1'b1;
            end
        end
        gray_bin[ANC_GRAY_IN_W-1] = acc_i[ANC_GRAY_IN_W-1];
        for (int i = ANC_GRAY_IN_W - 2; i >= 0; i--) begin
            gray_bin[i] = gray_bin[i+1] ^ acc_i[i];
        end
        gray_bcd = anc_bin2bcd({16'h0000, gray_bin});
    end

    assign dec_to_bin_o = bin_acc;
    assign bad_digit_o = bad;
    assign bin_to_dec_o = anc_bin2bcd(acc_i);
    // Upper 22 bits forced to zero
    assign gray_dec_o = {22'h00_0000, gray_bcd[ANC_GRAY_OUT_W-1:0]};
endmodule : anc_conv

// [test/anc_core_monitor.sv]
`timescale 1ns/1ps
module anc_core_monitor
    import anc_pkg::*;
#(
    parameter int MEM_AW = 16
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic [MEM_AW-1:0] mem_addr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_wr;
        mem_req_o && mem_we_o;
    endsequence
    sequence s_rd;
        mem_req_o && !mem_we_o;
    endsequence
    property p_bhold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_bdone;
        s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o;
    endproperty
    a_bdone: assert property (p_bdone) else $error("write channel not reopened");
    property p_blk;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_blk: assert property (p_blk) else $error("write taken while answering");
    property p_rans;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_rhold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data changed");
    property p_rdone;
        s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o;
    endproperty
    a_rdone: assert property (p_rdone) else $error("read channel not reopened");
    property p_wasc;
        s_wr ##1 s_wr |-> mem_addr_o == $past(mem_addr_o) + 1'b1;
    endproperty
    a_wasc: assert property (p_wasc) else $error("table writes not ascending");
    property p_rdwr;
        s_rd |-> ##[1:5] s_wr;
    endproperty
    a_rdwr: assert property (p_rdwr) else $error("table read not followed by write");
endmodule : anc_core_monitor

bind anc_core anc_core_monitor #(.MEM_AW(MEM_AW)) anc_core_monitor_i (.clk_i(clk_i),
    .reset_i(reset_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o));

// [test/anc_mem.sv]
`timescale 1ns/1ps
module anc_mem #(
    parameter int MEM_AW = 16
) (
    input wire logic clk_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [MEM_AW-1:0] mem_addr_i,
    input wire logic [15:0] mem_wdata_i,
    output logic [15:0] mem_rdata_o
);
    logic [15:0] mem [0:63];
    initial mem_rdata_o = 16'h0000;
    always @(posedge clk_i) begin
        if (mem_req_i && mem_we_i) mem[mem_addr_i[5:0]] <= mem_wdata_i;
        // Stale read data is inverted every cycle, so it matches the last read value only on alternate cycles
        if (mem_req_i && !mem_we_i) mem_rdata_o <= mem[mem_addr_i[5:0]];
        else mem_rdata_o <= ~mem_rdata_o;
    end
endmodule : anc_mem

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import anc_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rd_data;
    logic awready, wready, bvalid, arready, rvalid, mem_req, mem_we, irq;
    logic [1:0] bresp, rresp, rd_resp;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    int bad_count = 0, n_tests = 0, cyc = 0;
    always #2.5 clk_i = ~clk_i;
    anc_core anc_core_i (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .mem_req_o(mem_req), .mem_we_o(mem_we),
        .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .irq_o(irq));
    anc_mem anc_mem_i (.clk_i(clk_i), .mem_req_i(mem_req), .mem_we_i(mem_we),
        .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata));
    task automatic summarize;
        $display("checks %0d bad %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            summarize;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
        end while (!(w ? bvalid : rvalid));
        rd_data = rdata;
        rd_resp = w ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
    endtask : xf
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        xf(1'b0, a, 32'h0);
        chk(nm, e, rd_data);
    endtask : rc
    // Leaves the flags word in rd_data
    task automatic op(input logic [3:0] c);
        xf(1'b1, ANC_OFS_CTRL, {23'h0, 1'b1, 4'h0, c});
        // No poll limit: a hang ends at the cycle ceiling
        do begin
            xf(1'b0, ANC_OFS_FLAGS, 32'h0);
        end while (rd_data[ANC_FLAG_BUSY_BIT] !== 1'b0);
    endtask : op
    task automatic t_dec;
        xf(1'b1, ANC_OFS_ACC, 32'h0001_2345);
        op(ANC_OP_DEC_TO_RADIX2);
        chk("flags", 32'h0, rd_data & 32'hf);
        rc("acc", ANC_OFS_ACC, 32'h0000_3039);
        xf(1'b1, ANC_OFS_ACC, 32'h0000_001a);
        op(ANC_OP_DEC_TO_RADIX2);
        chk("flags", 32'h4, rd_data & 32'hf);
        xf(1'b1, ANC_OFS_ACC, 32'h0);
        op(ANC_OP_DEC_TO_RADIX2);
        chk("flags", 32'h1, rd_data & 32'hf);
    endtask : t_dec
    task automatic t_bcd;
        xf(1'b1, ANC_OFS_ACC, 32'h0000_3039);
        op(ANC_OP_RADIX2_TO_DEC);
        rc("acc", ANC_OFS_ACC, 32'h0001_2345);
        op(ANC_OP_ONES_COMPLEMENT);
        chk("flags", 32'h2, rd_data & 32'h3);
        rc("acc", ANC_OFS_ACC, 32'hfffe_dcba);
    endtask : t_bcd
    task automatic t_gray;
        xf(1'b1, ANC_OFS_ACC, 32'habcd_0214);
        op(ANC_OP_GRAY_TO_DEC);
        chk("flags", 32'h0, rd_data & 32'h3);
        rc("acc", ANC_OFS_ACC, 32'h0000_0199);
        xf(1'b1, ANC_OFS_ACC, 32'h0);
        op(ANC_OP_GRAY_TO_DEC);
        chk("flags", 32'h1, rd_data & 32'h3);
    endtask : t_gray
    task automatic t_tab5;
        anc_mem_i.mem[4] = 16'h1a2f;
        xf(1'b1, ANC_OFS_STACK1, 32'h1);
        xf(1'b1, ANC_OFS_ACC, 32'h4);
        xf(1'b1, ANC_OFS_OPERAND, 32'h8);
        op(ANC_OP_HEXDIGIT_TO_TEXT);
        chk("range", 32'h0, rd_data & 32'h8);
        chk("dst0", 32'h3141, {16'h0, anc_mem_i.mem[8]});
        chk("dst1", 32'h3246, {16'h0, anc_mem_i.mem[9]});
    endtask : t_tab5
    task automatic t_tab4;
        anc_mem_i.mem[16] = 16'h3439;
        anc_mem_i.mem[17] = 16'h4146;
        anc_mem_i.mem[18] = 16'h3043;
        xf(1'b1, ANC_OFS_STACK1, 32'h3);
        xf(1'b1, ANC_OFS_ACC, 32'h10);
        xf(1'b1, ANC_OFS_OPERAND, 32'h14);
        op(ANC_OP_TEXT_TO_HEXDIGIT);
        chk("dst0", 32'h49af, {16'h0, anc_mem_i.mem[20]});
        chk("dst1", 32'h0c00, {16'h0, anc_mem_i.mem[21]});
    endtask : t_tab4
    task automatic t_irq;
        xf(1'b1, ANC_OFS_INT_STAT, 32'h7);
        xf(1'b1, ANC_OFS_INT_MASK, 32'h5);
        xf(1'b1, ANC_OFS_STACK1, 32'h0);
        op(ANC_OP_TEXT_TO_HEXDIGIT);
        chk("range", 32'h8, rd_data & 32'h8);
        rc("stat", ANC_OFS_INT_STAT, 32'h5);
        chk("irq", 32'h1, {31'h0, irq});
        xf(1'b1, ANC_OFS_INT_STAT, 32'h7);
        repeat (2) @(posedge clk_i);
        chk("irq", 32'h0, {31'h0, irq});
        rc("hole", 8'h1c, 32'h0);
        chk("resp", {30'h0, ANC_RESP_SLVERR}, {30'h0, rd_resp});
        xf(1'b1, 8'h1c, 32'h0);
        chk("bresp", {30'h0, ANC_RESP_SLVERR}, {30'h0, rd_resp});
    endtask : t_irq
    initial begin
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        t_dec;
        t_bcd;
        t_gray;
        t_tab5;
        t_tab4;
        t_irq;
        summarize;
    end
endmodule : testbench
